// [common/pvms_pkg.sv]
// Constants and types for the vendor management status register slice.
// Assumes an APB master that places the device address and register index in paddr.
package pvms_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Address layout: paddr = {device, index, 2'b00}
	localparam int unsigned PVMS_ADDR_W = 23;
	localparam int unsigned PVMS_IDX_LSB = 2;
	localparam int unsigned PVMS_DEV_LSB = 18;
	localparam logic [4:0] PVMS_DEV_VND1 = 5'h1E;
	localparam logic [4:0] PVMS_DEV_VND2 = 5'h1F;

	// Register indices within their management device
	localparam logic [15:0] PVMS_IDX_LED = 16'h8C83;
	localparam logic [15:0] PVMS_IDX_ID_HIGH = 16'h0002;
	localparam logic [15:0] PVMS_IDX_ID_LOW = 16'h0003;
	localparam logic [15:0] PVMS_IDX_DEVS1 = 16'h0005;
	localparam logic [15:0] PVMS_IDX_DEVS2 = 16'h0006;
	localparam logic [15:0] PVMS_IDX_PRESENCE = 16'h0008;
	localparam logic [15:0] PVMS_IDX_STATUS = 16'h0011;
	localparam logic [15:0] PVMS_IDX_MASK = 16'h0021;

	////////////////////////////////////////////////////////////////////////////
	// Reset and constant values
	localparam logic [15:0] PVMS_LED_RST = 16'h0000;
	localparam logic [15:0] PVMS_DEVS1_VAL = 16'h008B;
	localparam logic [15:0] PVMS_DEVS2_VAL = 16'hC000;
	localparam logic [15:0] PVMS_PRESENCE_VAL = 16'h8000;
	localparam logic [15:0] PVMS_STATUS_RST = 16'h0000;
	localparam logic [15:0] PVMS_MASK_RST = 16'h2402;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned PVMS_LED_W = 2;
	localparam int unsigned PVMS_LED_A_LSB = 0;
	localparam int unsigned PVMS_LED_B_LSB = 2;
	localparam int unsigned PVMS_ORG_LSB = 10;
	localparam int unsigned PVMS_MODEL_LSB = 4;
	localparam int unsigned PVMS_REV_LSB = 0;
	localparam int unsigned PVMS_BIT_FATAL = 15;
	localparam int unsigned PVMS_BIT_FRAME = 14;
	localparam int unsigned PVMS_BIT_BUFFER = 13;
	localparam int unsigned PVMS_BIT_NEGO = 11;
	localparam int unsigned PVMS_BIT_LINK = 1;
	localparam int unsigned PVMS_BIT_MASK_SC = 15;

	typedef enum logic [1:0]
	{
		PVMS_POL_AUTO = 2'h0,
		PVMS_POL_HIGH = 2'h1,
		PVMS_POL_LOW = 2'h2
	} pvms_pol_e;

	typedef struct packed
	{
		logic fatal_error_event;
		logic frame_check_gen_event;
		logic host_buffer_error_event;
		logic negotiation_change_event;
		logic link_change_event;
	} pvms_evt_s;

endpackage

// [rtl/pvms_regs.sv]
// Vendor management register slice: LED drive sense, identity, devices-present
// words, presence status and the latched event status with its enable mask.
// Assumes an APB master on pclk; event inputs are one-cycle pulses on pclk.
//
// How it works
// [R1] Each LED has a 2-bit sense code: 0 autosense, 1 active high, 2 active low.
// [R2] The LED sense register resets to zero, so both LEDs autosense.
// [R3] The high identifier word is a fixed read-only value.
// [R4] The low identifier word holds organisation, model and revision fields, fixed.
// [R5] Devices-present word 1 reads constant 0x008B.
// [R6] Devices-present word 2 reads constant 0xC000.
// [R7] Presence field bits 15:14 reads 2'b10; bits 13:0 read zero.
// [R8] Status bits latch on events and clear when software reads them.
// [R9] Status bits latch whatever the mask; the mask only gates the interrupt.
// [R10] Reserved status bit is set only by a fatal internal error.
// [R11] Bit 14 latches frame check/generate events, bit 13 buffer errors.
// [R12] Bit 11 latches negotiation changes, bit 1 link changes; reset zero.
// [R13] Mask gates status bits onto the interrupt; resets to 0x2402.
// [R14] An event during the clearing read stays latched afterwards.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module pvms_regs
	import pvms_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h1234,  // Arbitrary value
	parameter logic [5:0] ORG_SLICE = 6'h15,    // Arbitrary value
	parameter logic [5:0] MODEL = 6'h0A,        // Arbitrary value
	parameter logic [3:0] REVISION = 4'h3,      // Arbitrary value
	parameter int unsigned NUM_LEDS = 2
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PVMS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire pvms_evt_s events,
	input wire logic [NUM_LEDS-1:0] led_request,
	input wire logic [NUM_LEDS-1:0] led_sensed_low,
	output logic [NUM_LEDS-1:0] led_drive,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic reg_hit(input logic [PVMS_ADDR_W-1:0] addr,
		input logic [4:0] dev, input logic [15:0] idx);
		reg_hit = (addr[PVMS_DEV_LSB +: 5] == dev) &&
			(addr[PVMS_IDX_LSB +: 16] == idx) && (addr[1:0] == 2'h0);
	endfunction

	logic [15:0] led_reg;
	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic [15:0] mask_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [NUM_LEDS-1:0] led_drive_reg;
	logic irq_reg;
	logic [15:0] id_low;
	logic [15:0] rd_value;
	logic rd_mapped;
	logic wr_allowed;
	logic setup_phase;
	logic access_phase;
	logic wr_led;
	logic wr_mask;
	logic rd_clear;
	logic [15:0] ev_vec;
	logic [15:0] wr_word;

	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;

	assign id_low = {ORG_SLICE, MODEL, REVISION}; // R4

	// Byte lanes 0 and 1 carry the 16-bit registers
	assign wr_word = {pstrb[1] ? pwdata[15:8] : mask_reg[15:8],
		pstrb[0] ? pwdata[7:0] : mask_reg[7:0]};

	////////////////////////////////////////////////////////////////////////////
	// Read mux, sampled in the setup cycle

	always_comb
	begin
		rd_value = 16'h0000;
		rd_mapped = 1'b1;
		wr_allowed = 1'b0;
		if (reg_hit(paddr, PVMS_DEV_VND1, PVMS_IDX_LED))
		begin
			rd_value = {12'h000, led_reg[3:0]};
			wr_allowed = 1'b1;
		end
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_ID_HIGH))
			rd_value = ID_HIGH; // R3
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_ID_LOW))
			rd_value = id_low; // R4
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_DEVS1))
			rd_value = PVMS_DEVS1_VAL; // R5
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_DEVS2))
			rd_value = PVMS_DEVS2_VAL; // R6
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_PRESENCE))
			rd_value = PVMS_PRESENCE_VAL; // R7
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_STATUS))
			rd_value = status_reg;
		else if (reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_MASK))
		begin
			rd_value = mask_reg;
			wr_allowed = 1'b1;
		end
		else
			rd_mapped = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// APB answer: zero wait states, data captured in setup

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end
		else if (setup_phase)
		begin
			// Writes to read-only words and unmapped addresses are refused
			prdata_reg <= (pwrite || !rd_mapped) ? 32'h00000000 : {16'h0000, rd_value};
			pslverr_reg <= pwrite ? !wr_allowed : !rd_mapped;
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	assign wr_led = access_phase && pwrite && !pslverr_reg &&
		reg_hit(paddr, PVMS_DEV_VND1, PVMS_IDX_LED);
	assign wr_mask = access_phase && pwrite && !pslverr_reg &&
		reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_MASK);
	assign rd_clear = access_phase && !pwrite &&
		reg_hit(paddr, PVMS_DEV_VND2, PVMS_IDX_STATUS);

	////////////////////////////////////////////////////////////////////////////
	// LED drive sense register

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			led_reg <= PVMS_LED_RST; // R2
		else if (wr_led && pstrb[0])
			led_reg <= {12'h000, pwdata[3:0]}; // R1
	end

	// Codes other than forced high or low fall back to the sensed wiring
	for (genvar i = 0; i < NUM_LEDS; i++)
	begin : g_led
		pvms_pol_e code;
		logic active_low;
		assign code = pvms_pol_e'(led_reg[PVMS_LED_A_LSB + i*PVMS_LED_W +: PVMS_LED_W]);
		assign active_low = (code == PVMS_POL_LOW) ||
			((code != PVMS_POL_HIGH) && led_sensed_low[i]); // R1

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				led_drive_reg[i] <= 1'b0;
			else
				led_drive_reg[i] <= led_request[i] ^ active_low; // R1
		end
	end

	assign led_drive = led_drive_reg;

	////////////////////////////////////////////////////////////////////////////
	// Event status, clear on read

	always_comb
	begin
		ev_vec = 16'h0000;
		ev_vec[PVMS_BIT_FATAL] = events.fatal_error_event; // R10
		ev_vec[PVMS_BIT_FRAME] = events.frame_check_gen_event; // R11
		ev_vec[PVMS_BIT_BUFFER] = events.host_buffer_error_event; // R11
		ev_vec[PVMS_BIT_NEGO] = events.negotiation_change_event; // R12
		ev_vec[PVMS_BIT_LINK] = events.link_change_event; // R12
	end

	// Only bits the reader actually saw are cleared, and new events win
	always_comb
	begin
		status_next = status_reg;
		if (rd_clear)
			status_next = status_reg & ~prdata_reg[15:0]; // R8
		status_next = status_next | ev_vec; // R9 R14
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_reg <= PVMS_STATUS_RST; // R12
		else
			status_reg <= status_next; // R8
	end

	////////////////////////////////////////////////////////////////////////////
	// Enable mask and interrupt

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_reg <= PVMS_MASK_RST; // R13
		else if (wr_mask)
			mask_reg <= wr_word;
		else
			mask_reg[PVMS_BIT_MASK_SC] <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_next & mask_reg); // R13 R9
	end

	assign irq = irq_reg;

endmodule // pvms_regs

// [tb/pvms_regs_monitor.sv]
// Checker for the vendor management register slice.
// Assumes it is bound onto pvms_regs and sees only its ports.
`timescale 1ns/1ps
module pvms_regs_monitor
	import pvms_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h1234,
	parameter logic [5:0] ORG_SLICE = 6'h15,
	parameter logic [5:0] MODEL = 6'h0A,
	parameter logic [3:0] REVISION = 4'h3
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PVMS_ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire pvms_evt_s events,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [15:0] idx = paddr[17:2];
	wire logic rd2 = psel && penable && !pwrite && paddr[22:18] == PVMS_DEV_VND2;
	sequence quiet_setup;
		psel && !penable && !pwrite && events == '0;
	endsequence
	sequence rd_stat;
		rd2 && idx == PVMS_IDX_STATUS && events == '0;
	endsequence
	//////////////////////////////////////////////////
	chk_devs1_value: assert property (rd2 && idx == PVMS_IDX_DEVS1 |-> prdata == 32'h8B)
		else $error("devices word 1 wrong");
	chk_devs2_value: assert property (rd2 && idx == PVMS_IDX_DEVS2 |-> prdata == 32'hC000)
		else $error("devices word 2 wrong");
	chk_presence_value: assert property (rd2 && idx == PVMS_IDX_PRESENCE |-> prdata == 32'h8000)
		else $error("presence word wrong");
	chk_id_high: assert property (rd2 && idx == PVMS_IDX_ID_HIGH |-> prdata == {16'h0, ID_HIGH})
		else $error("high id wrong");
	chk_id_low: assert property (rd2 && idx == PVMS_IDX_ID_LOW |->
		prdata == {16'h0, ORG_SLICE, MODEL, REVISION})
		else $error("low id wrong");
	// Events in the setup cycle miss the captured data, so both cycles must be quiet
	chk_read_clears: assert property (quiet_setup ##1 rd_stat |=> !irq)
		else $error("status not cleared by read");
	// A mask write acts one edge late on the interrupt, so skip the cycle after it too
	chk_irq_cause: assert property (!irq && events == '0 && !(psel && pwrite) &&
		!$past(psel && pwrite) |=> !irq)
		else $error("irq rose without cause");
	// Three idle cycles let a self-clearing mask bit settle first
	chk_irq_holds: assert property (irq && !psel && !$past(psel) && !$past(psel, 2) |=> irq)
		else $error("irq dropped without read");
endmodule // pvms_regs_monitor

bind pvms_regs pvms_regs_monitor #(.ID_HIGH(ID_HIGH), .ORG_SLICE(ORG_SLICE), .MODEL(MODEL),
	.REVISION(REVISION)) u_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .events, .irq);

// [tb/pvms_regs_tb.sv]
// Self-checking bench for the vendor management register slice.
// Assumes pvms_regs with its monitor bound; the bench drives every port.
`timescale 1ns/1ps
module pvms_regs_tb
	import pvms_pkg::*;
;
	localparam logic [15:0] ID_H = 16'h5A5A; // Arbitrary value
	localparam logic [15:0] ID_L = 16'hA916; // Arbitrary value
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [22:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, irq, err;
	pvms_evt_s events = '0;
	logic [1:0] led_request = '0, led_sensed_low = '0, led_drive;
	int num_errors = 0, n_compared = 0;
	pvms_regs #(.ID_HIGH(ID_H), .ORG_SLICE(ID_L[15:10]), .MODEL(ID_L[9:4]),
		.REVISION(ID_L[3:0]), .NUM_LEDS(2)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .events,
		.led_request, .led_sensed_low, .led_drive, .irq);
	//////////////////////////////////////////////////
	function automatic logic [31:0] st(input pvms_evt_s e);
		return {16'h0, e.fatal_error_event, e.frame_check_gen_event,
			e.host_buffer_error_event, 1'b0, e.negotiation_change_event, 9'h0,
			e.link_change_event, 1'b0};
	endfunction
	function automatic logic lx(input int c, input logic r, input logic s);
		return c == 1 ? r : c == 2 ? ~r : r ^ s;
	endfunction
	task automatic test_done();
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Starts one edge later so a release never meets a new request
	task automatic apb(input logic w, input logic [15:0] i, input logic [15:0] d,
		input pvms_evt_s ev);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i == PVMS_IDX_LED ? PVMS_DEV_VND1 : PVMS_DEV_VND2, i, 2'b00};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		events <= ev;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50)
			num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		events <= '0;
	endtask
	initial
	begin
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		#100us;
		num_errors++;
		test_done();
	end
	initial
	begin
		pvms_evt_s e;
		logic [15:0] m;
		void'($urandom(78779));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, PVMS_IDX_LED, 0, 0);
		chk(rd, 0);
		apb(0, PVMS_IDX_STATUS, 0, 0);
		chk(rd, 0);
		apb(0, PVMS_IDX_MASK, 0, 0);
		chk(rd, 32'h2402);
		apb(0, PVMS_IDX_ID_HIGH, 0, 0);
		chk(rd, {16'h0, ID_H});
		apb(0, PVMS_IDX_ID_LOW, 0, 0);
		chk(rd, {16'h0, ID_L});
		apb(1, PVMS_IDX_DEVS1, 16'hFFFF, 0);
		chk({31'h0, err}, 1);
		apb(0, PVMS_IDX_DEVS1, 0, 0);
		chk(rd, 32'h8B);
		apb(0, PVMS_IDX_DEVS2, 0, 0);
		chk(rd, 32'hC000);
		apb(0, PVMS_IDX_PRESENCE, 0, 0);
		chk(rd, 32'h8000);
		for (int k = 0; k < 9; k++)
		begin
			led_request <= 2'($urandom);
			led_sensed_low <= 2'($urandom);
			apb(1, PVMS_IDX_LED, {12'h0, 2'(k / 3), 2'(k % 3)}, 0);
			apb(0, PVMS_IDX_LED, 0, 0);
			chk(rd, {28'h0, 2'(k / 3), 2'(k % 3)});
			chk(led_drive, {lx(k / 3, led_request[1], led_sensed_low[1]),
				lx(k % 3, led_request[0], led_sensed_low[0])});
		end
		for (int k = 0; k < 30; k++)
		begin
			e = k < 5 ? pvms_evt_s'(5'h01 << k) : pvms_evt_s'(5'($urandom));
			m = k < 5 ? 16'h0 : 16'($urandom) & 16'h7FFF;
			apb(1, PVMS_IDX_MASK, m, 0);
			chk({31'h0, err}, 0);
			@(posedge pclk);
			events <= e;
			@(posedge pclk);
			events <= '0;
			@(posedge pclk);
			chk(irq, |(st(e) & {16'h0, m}));
			apb(0, PVMS_IDX_STATUS, 0, 0);
			chk(rd, st(e));
			apb(0, PVMS_IDX_STATUS, 0, 0);
			chk(rd, 0);
		end
		e = pvms_evt_s'(5'h02);
		apb(0, PVMS_IDX_STATUS, 0, e);
		chk(rd, 0);
		apb(0, PVMS_IDX_STATUS, 0, 0);
		chk(rd, st(e));
		test_done();
	end
endmodule // pvms_regs_tb
